/* File: pmsr_pkg.sv */
// Purpose: shared constants for the phy mode/special registers
// Assumes: 16-bit management registers, 50 MHz clock
// Notes: indices are management register numbers
package pmsr_pkg;
  // ----------------------------------------
  // register indices
  // ----------------------------------------
  localparam logic [4:0] IDX_ENERGY_CTRL = 5'h11;
  localparam logic [4:0] IDX_SPECIAL_MODES = 5'h12;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int EDPD_BIT = 13;
  localparam int ENERGY_BIT = 1;
  localparam int RSV_RW_BIT = 0;
  localparam int MODE_LSB = 5;
  localparam int ADDR_LSB = 0;
  // ----------------------------------------
  // mode codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    PMSR_M10_HALF = 3'h0,
    PMSR_M10_FULL = 3'h1,
    PMSR_M100_HALF = 3'h2,
    PMSR_M100_FULL = 3'h3,
    PMSR_MRSV4 = 3'h4,
    PMSR_MRSV5 = 3'h5,
    PMSR_MPOWERDOWN = 3'h6,
    PMSR_MALL_CAPABLE = 3'h7
  } pmsr_mode_t;
  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic RST_EDPD = 1'b0;
  localparam logic RST_ENERGY = 1'b1;
  localparam logic RST_RSV_RW = 1'b0;
  localparam int CLK_HZ = 50_000_000;
  localparam int ENERGY_TIMEOUT_MS = 256;
  localparam int ENERGY_TIMEOUT_CYC = (CLK_HZ / 1000) * ENERGY_TIMEOUT_MS;
endpackage

/* File: pmsr_energy_timer.sv */
// Purpose: line-energy flag with no-energy timeout
// Assumes: energy_valid is a synchronous level from the analog detector
// Notes: flag survives soft resets; only rst forces it to one
module pmsr_energy_timer #(
  parameter int TIMEOUT_CYC = pmsr_pkg::ENERGY_TIMEOUT_CYC
) (
  // clock and hardware reset
  input wire logic clk,
  input wire logic rst,
  // detector
  input wire logic energy_valid,
  // status
  output logic line_energy_present
);
  localparam int CW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYC - 1);
  logic [CW-1:0] quiet_cnt;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quiet_cnt <= '0;
      line_energy_present <= pmsr_pkg::RST_ENERGY;
    end else if (energy_valid) begin
      quiet_cnt <= '0;
      line_energy_present <= 1'b1;
    end else if (quiet_cnt == LAST) begin
      line_energy_present <= 1'b0;
    end else begin
      quiet_cnt <= quiet_cnt + 1'b1;
    end
  end

  property p_energy_set;
    @(posedge clk) disable iff (rst) energy_valid |=> line_energy_present;
  endproperty
  a_energy_set: assert property (p_energy_set) else $error("energy flag not set");

  // energy seen, then the line goes quiet for one cycle
  sequence s_energy_then_quiet;
    energy_valid ##1 !energy_valid;
  endsequence

  property p_energy_hold_while_quiet_short;
    @(posedge clk) disable iff (rst)
      s_energy_then_quiet |-> line_energy_present;
  endproperty
  a_energy_hold_while_quiet_short: assert property (p_energy_hold_while_quiet_short)
    else $error("energy flag dropped too early");

  property p_energy_timeout;
    @(posedge clk) disable iff (rst)
      (!energy_valid && quiet_cnt == LAST) |=> !line_energy_present;
  endproperty
  a_energy_timeout: assert property (p_energy_timeout) else $error("timeout missed");
endmodule // pmsr_energy_timer

/* File: pmsr_regs.sv */
// Purpose: energy control/status and special modes registers of a phy port
// Assumes: management access is a synchronous index/strobe port
// Notes: straps are sampled on the first edge after rst falls
// What this block does
// - two 16-bit registers sit at management indices 17 and 18.
// - bit 13 of index 17 enables energy-detect power-down, resets to 0.
// - read-only bit 1 shows line energy and clears after 256 ms without it.
// - the energy bit ignores soft resets and is set to 1 by hardware reset.
// - mode 000 is 10M half and 001 is 10M full, both without autonegotiation.
// - mode 010 is 100M half with tx/rx carrier sense, 011 is 100M full rx-only.
// - mode 110 powers down, 111 is all capable with autonegotiation, 100/101 reserved.
// - mode resets to 111 with the autoneg strap, else {0,speed,duplex}.
// - straps are latched at chip reset release and feed the defaults.
// - bits 4:0 set the management address and seed the scrambler key.
// - the address resets to the address-select strap value.
// - mode and address reload defaults only on a port phy reset.
// - the loader rewrites the special modes register after reset and on reload.
module pmsr_regs #(
  parameter int TIMEOUT_CYC = pmsr_pkg::ENERGY_TIMEOUT_CYC
) (
  // clock and hardware (chip-level) reset
  input wire logic clk,
  input wire logic rst,
  // configuration straps
  input wire logic autoneg_strap,
  input wire logic speed_strap,
  input wire logic duplex_strap,
  input wire logic [4:0] addr_sel_strap,
  // resets from other registers
  input wire logic soft_reset,
  input wire logic port_phy_reset,
  // non-volatile loader
  input wire logic loader_we,
  input wire logic [15:0] loader_data,
  // management access
  input wire logic [4:0] mgmt_index,
  input wire logic mgmt_we,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  // analog energy detector
  input wire logic energy_valid,
  // control to the phy
  output logic energy_detect_powerdown_enable,
  output logic [4:0] phy_management_address,
  output logic [4:0] scrambler_seed,
  output logic speed_100,
  output logic full_duplex,
  output logic autoneg_enable,
  output logic phy_powerdown,
  output logic crs_on_transmit,
  output logic mode_reserved
);
  logic strap_pending;
  logic [2:0] def_mode;
  logic [4:0] def_addr;
  logic [2:0] mode;
  logic rsv_rw;
  logic line_energy_present;
  logic rd_energy;
  logic rd_modes;

  // ----------------------------------------
  // strap capture
  // ----------------------------------------
  // async reset may only load constants, so straps land one edge later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_pending <= 1'b1;
      def_mode <= 3'h7;
      def_addr <= 5'h00;
    end else if (strap_pending) begin
      strap_pending <= 1'b0;
      def_mode <= autoneg_strap ? pmsr_pkg::PMSR_MALL_CAPABLE
                                : {1'b0, speed_strap, duplex_strap};
      def_addr <= addr_sel_strap;
    end
  end

  // ----------------------------------------
  // special modes register
  // ----------------------------------------
  // port phy reset alone restores defaults; soft reset leaves it alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode <= 3'h7;
      phy_management_address <= 5'h00;
    end else if (strap_pending) begin
      mode <= autoneg_strap ? pmsr_pkg::PMSR_MALL_CAPABLE
                            : {1'b0, speed_strap, duplex_strap};
      phy_management_address <= addr_sel_strap;
    end else if (port_phy_reset) begin
      mode <= def_mode;
      phy_management_address <= def_addr;
    end else if (loader_we) begin
      mode <= loader_data[pmsr_pkg::MODE_LSB +: 3];
      phy_management_address <= loader_data[pmsr_pkg::ADDR_LSB +: 5];
    end else if (mgmt_we && mgmt_index == pmsr_pkg::IDX_SPECIAL_MODES) begin
      mode <= mgmt_wdata[pmsr_pkg::MODE_LSB +: 3];
      phy_management_address <= mgmt_wdata[pmsr_pkg::ADDR_LSB +: 5];
    end
  end

  // ----------------------------------------
  // energy control register
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      energy_detect_powerdown_enable <= pmsr_pkg::RST_EDPD;
      rsv_rw <= pmsr_pkg::RST_RSV_RW;
    end else if (soft_reset) begin
      energy_detect_powerdown_enable <= pmsr_pkg::RST_EDPD;
      rsv_rw <= pmsr_pkg::RST_RSV_RW;
    end else if (mgmt_we && mgmt_index == pmsr_pkg::IDX_ENERGY_CTRL) begin
      energy_detect_powerdown_enable <= mgmt_wdata[pmsr_pkg::EDPD_BIT];
      rsv_rw <= mgmt_wdata[pmsr_pkg::RSV_RW_BIT];
    end
  end

  pmsr_energy_timer #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) i_pmsr_energy_timer (
    .clk(clk),
    .rst(rst),
    .energy_valid(energy_valid),
    .line_energy_present(line_energy_present)
  );

  // ----------------------------------------
  // read path
  // ----------------------------------------
  assign rd_energy = (mgmt_index == pmsr_pkg::IDX_ENERGY_CTRL);
  assign rd_modes = (mgmt_index == pmsr_pkg::IDX_SPECIAL_MODES);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mgmt_rdata <= 16'h0000;
    end else if (rd_energy) begin
      mgmt_rdata <= {2'h0, energy_detect_powerdown_enable, 11'h000,
                     line_energy_present, rsv_rw};
    end else if (rd_modes) begin
      mgmt_rdata <= {8'h00, mode, phy_management_address};
    end else begin
      mgmt_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  assign scrambler_seed = phy_management_address;

  always_comb begin
    speed_100 = 1'b0;
    full_duplex = 1'b0;
    autoneg_enable = 1'b0;
    phy_powerdown = 1'b0;
    crs_on_transmit = 1'b0;
    mode_reserved = 1'b0;
    case (pmsr_pkg::pmsr_mode_t'(mode))
      pmsr_pkg::PMSR_M10_HALF: begin
      end
      pmsr_pkg::PMSR_M10_FULL: full_duplex = 1'b1;
      pmsr_pkg::PMSR_M100_HALF: begin
        speed_100 = 1'b1;
        crs_on_transmit = 1'b1;
      end
      pmsr_pkg::PMSR_M100_FULL: begin
        speed_100 = 1'b1;
        full_duplex = 1'b1;
      end
      pmsr_pkg::PMSR_MPOWERDOWN: phy_powerdown = 1'b1;
      pmsr_pkg::PMSR_MALL_CAPABLE: begin
        autoneg_enable = 1'b1;
        speed_100 = 1'b1;
        full_duplex = 1'b1;
        crs_on_transmit = 1'b1;
      end
      default: mode_reserved = 1'b1;
    endcase
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_edpd_write;
    @(posedge clk) disable iff (rst)
      (mgmt_we && rd_energy && !soft_reset)
        |=> energy_detect_powerdown_enable == $past(mgmt_wdata[13]);
  endproperty
  a_edpd_write: assert property (p_edpd_write) else $error("edpd write lost");

  property p_phy_reset_defaults;
    @(posedge clk) disable iff (rst)
      (port_phy_reset && !strap_pending)
        |=> (mode == $past(def_mode) && phy_management_address == $past(def_addr));
  endproperty
  a_phy_reset_defaults: assert property (p_phy_reset_defaults)
    else $error("phy reset default wrong");

  property p_soft_keeps_mode;
    @(posedge clk) disable iff (rst)
      (soft_reset && !port_phy_reset && !loader_we && !mgmt_we && !strap_pending)
        |=> $stable(mode);
  endproperty
  a_soft_keeps_mode: assert property (p_soft_keeps_mode) else $error("soft reset hit mode");

  property p_loader;
    @(posedge clk) disable iff (rst)
      (loader_we && !port_phy_reset && !strap_pending)
        |=> phy_management_address == $past(loader_data[4:0]);
  endproperty
  a_loader: assert property (p_loader) else $error("loader write lost");

  property p_strap_mode;
    @(posedge clk) disable iff (rst)
      (strap_pending && autoneg_strap) |=> mode == 3'h7;
  endproperty
  a_strap_mode: assert property (p_strap_mode) else $error("strap default wrong");

  property p_rsv_zero;
    @(posedge clk) disable iff (rst)
      rd_modes |=> mgmt_rdata[15:8] == 8'h00;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits nonzero");

  property p_energy_read;
    @(posedge clk) disable iff (rst)
      rd_energy |=> mgmt_rdata[1] == $past(line_energy_present);
  endproperty
  a_energy_read: assert property (p_energy_read) else $error("energy read wrong");

  // a plain management write must reach the scrambler seed as well as the address
  property p_seed;
    @(posedge clk) disable iff (rst)
      (mgmt_we && rd_modes && !strap_pending && !port_phy_reset && !loader_we)
        |=> scrambler_seed == $past(mgmt_wdata[4:0]);
  endproperty
  a_seed: assert property (p_seed) else $error("seed mismatch");
endmodule // pmsr_regs

/* File: test_pmsr_regs.sv */
// Purpose: self-checking bench for the phy energy and special modes registers
// Assumes: energy timeout shortened to TO cycles; straps held steady around reset
// Notes: checks are queued by the driver and compared by a separate monitor
module test_pmsr_regs;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int TO = 20;
  logic clk, rst, autoneg_strap, speed_strap, duplex_strap, energy_valid;
  logic soft_reset, port_phy_reset, loader_we, mgmt_we, req, req_d;
  logic [4:0] addr_sel_strap, mgmt_index, addr, seed, a;
  logic [15:0] loader_data, mgmt_wdata, mgmt_rdata;
  logic edpd, spd, fd, an, pd, crs, rsv;
  logic [34:0] exp_q[$];
  logic [34:0] e;
  logic [16:0] got;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;

  pmsr_regs #(.TIMEOUT_CYC(TO)) i_pmsr_regs (
    .clk(clk), .rst(rst), .autoneg_strap(autoneg_strap), .speed_strap(speed_strap),
    .duplex_strap(duplex_strap), .addr_sel_strap(addr_sel_strap),
    .soft_reset(soft_reset), .port_phy_reset(port_phy_reset), .loader_we(loader_we),
    .loader_data(loader_data), .mgmt_index(mgmt_index), .mgmt_we(mgmt_we),
    .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .energy_valid(energy_valid),
    .energy_detect_powerdown_enable(edpd), .phy_management_address(addr),
    .scrambler_seed(seed), .speed_100(spd), .full_duplex(fd), .autoneg_enable(an),
    .phy_powerdown(pd), .crs_on_transmit(crs), .mode_reserved(rsv));

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------
  // monitor: compare half a cycle after the registered read lands
  // ----------------------------------------
  always @(posedge clk) begin
    req_d <= req;
  end

  // falling edge keeps the look clear of the edge that launches the data
  always @(negedge clk) begin
    if (++cycles == 3000) begin
      miscompares++;
      wrap_up();
    end else if (req_d) begin
      e = exp_q.pop_front();
      got = e[34] ? {edpd, addr, seed, spd, fd, an, pd, crs, rsv} : {1'h0, mgmt_rdata};
      tests_run++;
      if ((got & e[33:17]) !== e[16:0]) begin
        miscompares++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got & e[33:17], e[16:0]);
      end
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic wrap_up();
    if (miscompares == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic sel, input logic [4:0] idx, input logic [16:0] mask,
                     input logic [16:0] val);
    @(negedge clk);
    mgmt_index = idx;
    exp_q.push_back({sel, mask, val & mask});
    req = 1'h1;
    @(negedge clk);
    req = 1'h0;
  endtask

  task automatic rd(input logic [4:0] idx, input logic [15:0] val);
    chk(1'h0, idx, 17'h0FFFF, {1'h0, val});
  endtask

  // decode mask/value for {speed, duplex, autoneg, powerdown, crs, reserved}
  function automatic logic [11:0] dec(input logic [2:0] md);
    case (md)
      3'h0, 3'h1: dec = {6'h3D, 1'h0, md[0], 4'h0};
      3'h2: dec = 12'hFE2;
      3'h3: dec = 12'hFF0;
      3'h4, 3'h5: dec = 12'h041;
      3'h6: dec = 12'h144;
      default: dec = 12'h348;
    endcase
  endfunction

  task automatic chkdec(input logic en, input logic [4:0] ad, input logic [2:0] md);
    logic [11:0] d;
    d = dec(md);
    chk(1'h1, mgmt_index, {11'h7FF, d[11:6]}, {en, ad, ad, d[5:0]});
  endtask

  task automatic wr(input logic [4:0] idx, input logic [15:0] d);
    @(negedge clk);
    mgmt_index = idx;
    mgmt_wdata = d;
    mgmt_we = 1'h1;
    @(negedge clk);
    mgmt_we = 1'h0;
  endtask

  task automatic pulse(input int which);
    @(negedge clk);
    case (which)
      0: soft_reset = 1'h1;
      1: port_phy_reset = 1'h1;
      default: loader_we = 1'h1;
    endcase
    @(negedge clk);
    {soft_reset, port_phy_reset, loader_we} = 3'h0;
  endtask

  task automatic hard_reset();
    @(negedge clk);
    rst = 1'h1;
    repeat (10) @(negedge clk);
    rst = 1'h0;
    repeat (2) @(negedge clk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'h1;
    {soft_reset, port_phy_reset, loader_we, mgmt_we, req} = 5'h00;
    energy_valid = 1'h1;
    mgmt_index = 5'h00;
    mgmt_wdata = 16'h0000;
    loader_data = 16'h0000;
    void'($urandom(62));
    autoneg_strap = 1'h0;
    speed_strap = 1'($urandom);
    duplex_strap = 1'($urandom);
    addr_sel_strap = 5'($urandom);
    hard_reset();
    rd(5'h11, 16'h0002);
    rd(5'h12, {8'h00, 1'h0, speed_strap, duplex_strap, addr_sel_strap});
    chkdec(1'h0, addr_sel_strap, {1'h0, speed_strap, duplex_strap});
    wr(5'h11, 16'hFFFF);
    rd(5'h11, 16'h2003);
    for (int i = 0; i < 8; i++) begin
      a = 5'($urandom);
      wr(5'h12, {8'($urandom), i[2:0], a});
      rd(5'h12, {8'h00, i[2:0], a});
      chkdec(1'h1, a, i[2:0]);
    end
    pulse(0);
    rd(5'h11, 16'h0002);
    rd(5'h12, {8'h00, 3'h7, a});
    // straps move after release; defaults must keep the latched values
    {speed_strap, duplex_strap, addr_sel_strap} = ~{speed_strap, duplex_strap, addr_sel_strap};
    pulse(1);
    rd(5'h12, {8'h00, 1'h0, ~speed_strap, ~duplex_strap, ~addr_sel_strap});
    loader_data = {8'($urandom), 3'h1, 5'($urandom)};
    pulse(2);
    rd(5'h12, loader_data & 16'h00FF);
    wr(5'h10, 16'hFFFF);
    wr(5'h13, 16'hFFFF);
    rd(5'h05, 16'h0000);
    rd(5'h12, loader_data & 16'h00FF);
    rd(5'h11, 16'h0002);
    // line goes quiet: flag must hold, then drop after the timeout
    energy_valid = 1'h0;
    repeat (8) @(negedge clk);
    rd(5'h11, 16'h0002);
    repeat (TO) @(negedge clk);
    rd(5'h11, 16'h0000);
    energy_valid = 1'h1;
    @(negedge clk);
    energy_valid = 1'h0;
    rd(5'h11, 16'h0002);
    repeat (TO + 5) @(negedge clk);
    autoneg_strap = 1'h1;
    addr_sel_strap = 5'($urandom);
    hard_reset();
    rd(5'h11, 16'h0002);
    rd(5'h12, {8'h00, 3'h7, addr_sel_strap});
    repeat (3) @(negedge clk);
    wrap_up();
  end
endmodule // test_pmsr_regs
